/* File: core/sms_pkg.sv */
// shared types and constants of the serial master/slave port
package sms_pkg;

	typedef struct packed {
		logic irq_en;            // interrupt request on transfer done
		logic enable;            // serial_port_enable
		logic lsb_first;         // bit order
		logic controller_select; // 1 master, 0 slave
		logic cpol;              // sck idle level
		logic cpha;              // 1 sample on trailing edge
		logic [1:0] rate;        // rate_select high and rate_select_low
		logic double_speed;      // halves the master divider
	} sms_ctrl_s;

	typedef enum logic {
		SMS_IDLE = 1'b0,
		SMS_SHIFT = 1'b1
	} sms_xfer_e;

	localparam sms_ctrl_s CTRL_RST = '0;
	localparam int BYTE_BITS = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int ST_DONE_BIT = 7;
	localparam int ST_CLASH_BIT = 6;
	localparam int ST_DBL_BIT = 0;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// clk cycles per sck half period, index {double_speed, rate}
	// divides by 4,16,64,128 and, doubled, by 2,8,32,64
	localparam logic [6:0] HALF_DIV [8] = '{
		7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20
	};

endpackage : sms_pkg

/* File: core/sms_port.sv */
// serial master/slave port with receive stream fifo
`timescale 1ns/100ps
`default_nettype none

module sms_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // clock
	input wire logic rst_n, // synchronised reset, low active
	input wire logic in_valid, // push request
	output logic in_ready, // room for one word
	input wire logic [WIDTH-1:0] in_data, // pushed word
	output logic out_valid, // word available
	input wire logic out_ready, // pop request
	output logic [WIDTH-1:0] out_data // oldest word
);
	localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	if (DEPTH < 2) begin : g_bad_depth
		$error("sms_fifo needs DEPTH of at least 2");
	end

	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule : sms_fifo

module sms_port #(
	parameter int FIFO_DEPTH = sms_pkg::FIFO_DEPTH
) (
	input wire logic clk, // 20 MHz clock
	input wire logic resetn, // async reset, low active
	input wire logic ctrl_wr, // control write strobe
	input wire sms_pkg::sms_ctrl_s ctrl_wdata, // control write value
	output sms_pkg::sms_ctrl_s ctrl_rdata, // control register
	input wire logic stat_rd, // status read strobe
	output logic [7:0] stat_rdata, // status register
	input wire logic data_wr, // data register write strobe
	input wire logic [7:0] data_wdata, // byte to send
	input wire logic data_rd, // data register read strobe
	output logic [7:0] data_rdata, // receive buffer register
	input wire logic irq_ack, // interrupt serviced
	output logic irq, // interrupt request
	output logic rx_valid, // received byte stream valid
	output logic [7:0] rx_data, // received byte stream
	input wire logic rx_ready, // stream consumer ready
	input wire logic dir_mosi_out, // software direction of mosi
	input wire logic dir_miso_out, // software direction of miso
	input wire logic dir_sck_out, // software direction of sck
	input wire logic dir_ss_out, // slave select pin is an output
	input wire logic sck_i, // sck pin level
	output logic sck_o, // sck drive level
	output logic sck_oe, // sck drive enable
	input wire logic mosi_i, // mosi pin level
	output logic mosi_o, // mosi drive level
	output logic mosi_oe, // mosi drive enable
	input wire logic miso_i, // miso pin level
	output logic miso_o, // miso drive level
	output logic miso_oe, // miso drive enable
	input wire logic ss_n_i // slave select pin, low active
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [3:0] meta_q;
	logic [3:0] pin_q;
	logic sck_prev_q;
	sms_pkg::sms_ctrl_s ctrl_q;
	sms_pkg::sms_xfer_e state_q;
	logic [6:0] div_q;
	logic sck_q;
	logic [7:0] sr_q;
	logic [2:0] cnt_q;
	logic cap_q;
	logic [7:0] rbuf_q;
	logic done_q;
	logic clash_q;
	logic done_arm_q;
	logic clash_arm_q;
	logic irq_q;
	logic [7:0] stat_q;
	logic mosi_o_q;
	logic miso_o_q;
	logic mosi_oe_q;
	logic miso_oe_q;
	logic sck_oe_q;
	logic rxv_q;
	logic [7:0] rxd_q;

	logic sck_s;
	logic mosi_s;
	logic miso_s;
	logic ss_s;
	logic master;
	logic slave;
	logic slave_sel;
	logic fault;
	logic [6:0] half;
	logic div_hit;
	logic s_edge;
	logic lead_ev;
	logic trail_ev;
	logic busy;
	logic wr_ok;
	logic in_bit;
	logic new_bit;
	logic out_bit;
	logic [7:0] shifted;
	logic next_out;
	logic byte_done;
	logic data_acc;
	logic push_ready;
	logic fifo_valid;
	logic fifo_ready;
	logic [7:0] fifo_data;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// only pin_q is looked at; meta_q may be metastable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 4'hF;
			pin_q <= 4'hF;
			// same level as the synchroniser's reset, so no false edge
			sck_prev_q <= 1'b1;
		end else begin
			meta_q <= {sck_i, mosi_i, miso_i, ss_n_i};
			pin_q <= meta_q;
			sck_prev_q <= pin_q[3];
		end
	end
	assign sck_s = pin_q[3];
	assign mosi_s = pin_q[2];
	assign miso_s = pin_q[1];
	assign ss_s = pin_q[0];

	assign master = ctrl_q.enable & ctrl_q.controller_select;
	assign slave = ctrl_q.enable & ~ctrl_q.controller_select;
	assign slave_sel = slave & ~ss_s;
	assign fault = master & ~dir_ss_out & ~ss_s;

	assign half = sms_pkg::HALF_DIV[{ctrl_q.double_speed, ctrl_q.rate}];
	// a full stream fifo holds the master clock, so no master byte is dropped
	assign div_hit = (state_q == sms_pkg::SMS_SHIFT) && push_ready
		&& (div_q == half - 7'h01);
	// slave sck is oversampled: phases shorter than one clock can be missed
	assign s_edge = slave_sel && (sck_s != sck_prev_q);
	assign lead_ev = (div_hit && (sck_q == ctrl_q.cpol))
		|| (s_edge && (sck_s != ctrl_q.cpol));
	assign trail_ev = (div_hit && (sck_q != ctrl_q.cpol))
		|| (s_edge && (sck_s == ctrl_q.cpol));

	assign busy = (state_q == sms_pkg::SMS_SHIFT)
		|| (slave_sel && (cnt_q != 3'h0));
	assign wr_ok = data_wr && !busy && ctrl_q.enable;
	assign data_acc = data_wr | data_rd;

	assign in_bit = master ? miso_s : mosi_s;
	assign new_bit = ctrl_q.cpha ? in_bit : cap_q;
	assign out_bit = ctrl_q.lsb_first ? sr_q[0] : sr_q[7];
	assign shifted = ctrl_q.lsb_first ? {new_bit, sr_q[7:1]}
		: {sr_q[6:0], new_bit};
	assign byte_done = trail_ev && (cnt_q == sms_pkg::LAST_BIT);
	// cpha 0 moves the data line on the trailing edge itself: at the
	// fastest rate it would otherwise move with the next leading edge
	assign next_out = wr_ok
		? (ctrl_q.lsb_first ? data_wdata[0] : data_wdata[7])
		: (trail_ev && !ctrl_q.cpha)
		? (ctrl_q.lsb_first ? shifted[0] : shifted[7]) : out_bit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= sms_pkg::CTRL_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= ctrl_wdata;
			end
			if (fault) begin
				ctrl_q.controller_select <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= sms_pkg::SMS_IDLE;
			div_q <= 7'h00;
			sck_q <= 1'b0;
		end else begin
			unique case (state_q)
				sms_pkg::SMS_IDLE: begin
					sck_q <= ctrl_q.cpol;
					div_q <= 7'h00;
					// slave select is left to software
					if (wr_ok && master) begin
						state_q <= sms_pkg::SMS_SHIFT;
					end
				end
				sms_pkg::SMS_SHIFT: begin
					if (div_hit) begin
						div_q <= 7'h00;
						sck_q <= ~sck_q;
					end else if (push_ready) begin
						div_q <= div_q + 7'h01;
					end
					if (!master || fault || byte_done) begin
						state_q <= sms_pkg::SMS_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_q <= sms_pkg::DATA_RST;
			cap_q <= 1'b0;
		end else begin
			if (wr_ok) begin
				sr_q <= data_wdata;
			end else if (trail_ev) begin
				sr_q <= shifted;
			end
			if (lead_ev) begin
				cap_q <= in_bit;
			end
		end
	end

	// a deselected slave holds its counter at zero, so any rise of select
	// drops a partial byte; the master relies on that between packets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
		end else if (!ctrl_q.enable || (slave && ss_s) || fault) begin
			cnt_q <= 3'h0;
		end else if (wr_ok && master) begin
			cnt_q <= 3'h0;
		end else if (trail_ev) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rbuf_q <= sms_pkg::DATA_RST;
		end else if (byte_done) begin
			rbuf_q <= shifted;
		end
	end

	// hardware set wins over any clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			done_arm_q <= 1'b0;
		end else begin
			if (byte_done || fault) begin
				done_q <= 1'b1;
			end else if (irq_ack || (done_arm_q && data_acc)) begin
				done_q <= 1'b0;
			end
			if (stat_rd && done_q) begin
				done_arm_q <= 1'b1;
			end else if (data_acc) begin
				done_arm_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clash_q <= 1'b0;
			clash_arm_q <= 1'b0;
		end else begin
			if (data_wr && busy) begin
				clash_q <= 1'b1;
			end else if (clash_arm_q && data_acc) begin
				clash_q <= 1'b0;
			end
			if (stat_rd && clash_q) begin
				clash_arm_q <= 1'b1;
			end else if (data_acc) begin
				clash_arm_q <= 1'b0;
			end
		end
	end

	// no sleep input: the port and its request run on while the cpu idles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
			stat_q <= sms_pkg::STAT_RST;
		end else begin
			irq_q <= done_q & ctrl_q.irq_en;
			stat_q <= sms_pkg::STAT_RST;
			stat_q[sms_pkg::ST_DONE_BIT] <= done_q;
			stat_q[sms_pkg::ST_CLASH_BIT] <= clash_q;
			stat_q[sms_pkg::ST_DBL_BIT] <= ctrl_q.double_speed;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mosi_o_q <= 1'b0;
			miso_o_q <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_oe_q <= 1'b0;
			sck_oe_q <= 1'b0;
		end else begin
			mosi_o_q <= next_out;
			miso_o_q <= next_out;
			mosi_oe_q <= master & dir_mosi_out;
			sck_oe_q <= master & dir_sck_out;
			miso_oe_q <= slave_sel & dir_miso_out;
		end
	end

	sms_fifo #(
		.WIDTH(sms_pkg::BYTE_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(byte_done),
		.in_ready(push_ready),
		.in_data(shifted),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	assign fifo_ready = ~rxv_q | rx_ready;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxv_q <= 1'b0;
			rxd_q <= sms_pkg::DATA_RST;
		end else if (fifo_ready) begin
			rxv_q <= fifo_valid;
			rxd_q <= fifo_data;
		end
	end

	assign ctrl_rdata = ctrl_q;
	assign stat_rdata = stat_q;
	assign data_rdata = rbuf_q;
	assign irq = irq_q;
	assign rx_valid = rxv_q;
	assign rx_data = rxd_q;
	assign sck_o = sck_q;
	assign sck_oe = sck_oe_q;
	assign mosi_o = mosi_o_q;
	assign mosi_oe = mosi_oe_q;
	assign miso_o = miso_o_q;
	assign miso_oe = miso_oe_q;
endmodule : sms_port

`default_nettype wire

/* File: sim/sms_port_monitor.sv */
// assertion checker on the serial port pins and flags
`timescale 1ns/100ps
`default_nettype none
module sms_port_monitor (
	input wire logic clk, // clock
	input wire logic resetn, // reset, low
	input wire sms_pkg::sms_ctrl_s ctrl_rdata, // control
	input wire logic [7:0] stat_rdata, // status
	input wire logic irq, // request
	input wire logic irq_ack, // serviced
	input wire logic rx_valid, // stream valid
	input wire logic rx_ready, // stream ready
	input wire logic [7:0] rx_data, // stream byte
	input wire logic sck_o, // sck level
	input wire logic sck_oe, // sck drive
	input wire logic miso_oe, // miso drive
	input wire logic dir_sck_out, // sck dir
	input wire logic dir_miso_out, // miso dir
	input wire logic dir_ss_out, // ss dir
	input wire logic ss_n_i // select, low
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic mst, sck_en, miso_en, fault;
	assign mst = ctrl_rdata.enable & ctrl_rdata.controller_select;
	assign sck_en = mst & dir_sck_out;
	assign miso_en = ctrl_rdata.enable & ~ctrl_rdata.controller_select
		& dir_miso_out;
	assign fault = mst & ~dir_ss_out & ~ss_n_i;
	sequence s_done;
		$rose(stat_rdata[7]) && mst;
	endsequence
	sequence s_fault;
		fault [*3];
	endsequence
	property p_irq;
		irq == (stat_rdata[7] & $past(ctrl_rdata.irq_en));
	endproperty
	property p_sck;
		sck_oe == $past(sck_en);
	endproperty
	property p_miso;
		miso_oe |-> $past(miso_en);
	endproperty
	property p_desel;
		ss_n_i [*4] |-> !miso_oe;
	endproperty
	property p_stop;
		s_done |-> $stable(sck_o) [*4];
	endproperty
	property p_ack;
		irq_ack |-> ##2 !stat_rdata[7] && !irq;
	endproperty
	property p_hold;
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
	endproperty
	// slack of one cycle covers the pin synchroniser
	property p_fault;
		s_fault |-> ##[1:2] (!ctrl_rdata.controller_select ##1 stat_rdata[7]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq wrong");
	a_sck: assert property (p_sck) else $error("sck drive wrong");
	a_miso: assert property (p_miso) else $error("miso drive");
	a_desel: assert property (p_desel) else $error("miso on");
	a_stop: assert property (p_stop) else $error("sck runs on");
	a_ack: assert property (p_ack) else $error("ack no clear");
	a_hold: assert property (p_hold) else $error("stream lost");
	a_fault: assert property (p_fault) else $error("no fault");
endmodule : sms_port_monitor
bind sms_port sms_port_monitor mon_u (.clk(clk), .resetn(resetn),
	.ctrl_rdata(ctrl_rdata), .stat_rdata(stat_rdata), .irq(irq),
	.irq_ack(irq_ack), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.rx_data(rx_data), .sck_o(sck_o), .sck_oe(sck_oe), .miso_oe(miso_oe),
	.dir_sck_out(dir_sck_out), .dir_miso_out(dir_miso_out),
	.dir_ss_out(dir_ss_out), .ss_n_i(ss_n_i));
`default_nettype wire

/* File: sim/sms_peer.sv */
// far-end serial device model, any clock mode, msb first
`timescale 1ns/100ps
`default_nettype none
module sms_peer (
	input wire logic sck, // serial clock
	input wire logic ss_n, // select, low
	input wire logic mosi, // data in
	input wire logic [7:0] tx, // byte to return
	input wire logic cpol, // sck idle level
	input wire logic cpha, // 1 samples on the trailing edge
	output logic miso, // data out
	output logic [7:0] rx // bits taken
);
	logic [7:0] sr;
	int got;
	initial begin
		miso = 1'b0;
		rx = 8'h00;
		sr = 8'h00;
		got = 0;
	end
	always @(negedge ss_n) begin
		sr = tx;
		miso = tx[7];
		got = 0;
	end
	// released line has no pull, so show the opposite of the last bit
	always @(posedge ss_n) miso = ~miso;
	// the first bit is out since select, so no shift before a sample
	always @(sck) if (!ss_n) begin
		if ((sck != cpol) != cpha) begin
			rx = {rx[6:0], mosi};
			got++;
		end else if (got > 0) begin
			sr = {sr[6:0], sr[7]};
			miso = sr[7];
		end
	end
endmodule : sms_peer
`default_nettype wire

/* File: sim/sms_tb.sv */
// self-checking bench of the serial master/slave port
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk, resetn, ctrl_wr, stat_rd, data_wr, data_rd, irq_ack;
	logic rx_ready, dmo, dmi, dsk, dss, tsck, tmosi, ss_n;
	logic irq, rxv, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pmiso;
	logic [7:0] wdat, ptx, prx, stat, rdat, rxd, got, b, e;
	sms_pkg::sms_ctrl_s ctrl, crd, c;
	int error_cnt, checks_done, cycles, n, h, got_n;
	int div[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	logic [7:0] exp_q[$];
	wire logic sck = sck_oe ? sck_o : tsck;
	wire logic mosi = mosi_oe ? mosi_o : tmosi;
	wire logic miso = miso_oe ? miso_o : pmiso;
	sms_port #(.FIFO_DEPTH(8)) dut_u (.clk(clk), .resetn(resetn),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl), .ctrl_rdata(crd),
		.stat_rd(stat_rd), .stat_rdata(stat), .data_wr(data_wr),
		.data_wdata(wdat), .data_rd(data_rd), .data_rdata(rdat),
		.irq_ack(irq_ack), .irq(irq), .rx_valid(rxv), .rx_data(rxd),
		.rx_ready(rx_ready), .dir_mosi_out(dmo), .dir_miso_out(dmi),
		.dir_sck_out(dsk), .dir_ss_out(dss), .sck_i(sck), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_n_i(ss_n));
	sms_peer peer_u (.sck(sck), .ss_n(ss_n), .mosi(mosi), .tx(ptx),
		.cpol(ctrl.cpol), .cpha(ctrl.cpha), .miso(pmiso), .rx(prx));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	function automatic logic [7:0] rev(input logic [7:0] v);
		rev = {<<{v}};
	endfunction : rev
	task check(input string nm, input logic [7:0] seen, input logic [7:0] ex);
		checks_done++;
		if (seen !== ex) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, ex, seen);
		end
	endtask : check
	task wr_ctrl(input sms_pkg::sms_ctrl_s v);
		@(posedge clk) ctrl <= v;
		ctrl_wr <= 1'b1;
		@(posedge clk) ctrl_wr <= 1'b0;
	endtask : wr_ctrl
	// strobes {irq_ack, data_rd, stat_rd, data_wr} for one cycle
	task hit(input logic [3:0] m);
		@(posedge clk) {irq_ack, data_rd, stat_rd, data_wr} <= m;
		@(posedge clk) {irq_ack, data_rd, stat_rd, data_wr} <= 4'h0;
	endtask : hit
	task wait_done;
		n = 0;
		while (stat[7] !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 4000) error_cnt++;
		repeat (4) @(posedge clk);
	endtask : wait_done
	task select(input logic [7:0] t);
		@(posedge clk) ss_n <= 1'b1;
		ptx <= t;
		@(posedge clk) ss_n <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : select
	// phases of six clocks keep the slave's sck sampling safe
	task slv_xfer(input logic [7:0] vb, input int nb);
		@(posedge clk) ss_n <= 1'b0;
		for (int k = 7; k > 7 - nb; k--) begin
			tmosi <= vb[k];
			repeat (5) @(posedge clk);
			@(negedge clk) got[k] = miso;
			@(posedge clk) tsck <= 1'b1;
			repeat (6) @(posedge clk);
			tsck <= 1'b0;
		end
		repeat (6) @(posedge clk);
		ss_n <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask : slv_xfer
	task stop_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial begin
		{resetn, ctrl_wr, stat_rd, data_wr, data_rd, irq_ack, rx_ready} = '0;
		{dmo, dsk, dss, dmi, tsck, tmosi, ss_n} = 7'h71;
		ctrl = '0;
		wdat = 8'h00;
		ptx = 8'h00;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(negedge clk);
		check("ctrl", {crd[8:2], |crd[1:0]}, 8'h00);
		check("stat", stat, 8'h00);
		for (int i = 0; i < 8; i++) begin
			c = '0;
			c.irq_en = 1'b1;
			c.enable = 1'b1;
			c.controller_select = 1'b1;
			c.lsb_first = i[0];
			{c.double_speed, c.rate} = 3'(i);
			{c.cpol, c.cpha} = 2'(i >> 1);
			wr_ctrl(c);
			h = div[i] / 2;
			b = 8'hA1 ^ 8'(i * 37);
			// fast rates beat the miso synchroniser, so send a flat byte
			e = (h < 4) ? {8{b[3]}} : ~b;
			select(e);
			wdat <= b;
			hit(4'h1);
			wait_done();
			check("time", 8'(n >= 16 * h && n <= 16 * h + 6), 8'h01);
			check("sent", prx, i[0] ? rev(b) : b);
			e = i[0] ? rev(e) : e;
			check("rbuf", rdat, e);
			check("irq", {7'h00, irq}, 8'h01);
			exp_q.push_back(e);
			hit(4'h8);
		end
		c.lsb_first = 1'b0;
		{c.double_speed, c.rate} = 3'h1;
		wr_ctrl(c);
		select(8'h5A);
		wdat <= 8'h96;
		hit(4'h1);
		wdat <= 8'h69;
		hit(4'h1);
		wait_done();
		check("clash", stat, 8'hC0);
		check("sent", prx, 8'h96);
		exp_q.push_back(8'h5A);
		hit(4'h2);
		hit(4'h4);
		repeat (3) @(negedge clk);
		check("clear", stat, 8'h00);
		@(posedge clk) ss_n <= 1'b1;
		rx_ready <= 1'b1;
		got_n = 0;
		for (int k = 0; k < 40 && got_n < 9; k++) begin
			@(negedge clk);
			if (rxv === 1'b1) begin
				check("stream", rxd, exp_q[got_n]);
				got_n++;
			end
		end
		check("count", 8'(got_n), 8'h09);
		@(posedge clk) dss <= 1'b0;
		ss_n <= 1'b0;
		repeat (8) @(negedge clk);
		check("mode", {7'h00, crd.controller_select}, 8'h00);
		check("fault", stat, 8'h80);
		@(posedge clk) ss_n <= 1'b1;
		hit(4'h8);
		c = '0;
		c.enable = 1'b1;
		c.irq_en = 1'b1;
		wr_ctrl(c);
		{dmo, dsk, dmi} <= 3'h1;
		wdat <= 8'hB4;
		hit(4'h1);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk) tsck <= ~tsck;
			@(negedge clk) check("tri", {7'h00, miso_oe}, 8'h00);
		end
		slv_xfer(8'h4D, 8);
		check("miso", got, 8'hB4);
		check("rbuf", rdat, 8'h4D);
		check("done", stat, 8'h80);
		hit(4'h8);
		slv_xfer(8'hF0, 4);
		check("part", stat, 8'h00);
		slv_xfer(8'h27, 8);
		check("rbuf", rdat, 8'h27);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
